// ==== verilog/pfcsg_gate.sv ====
// switch gating, dead-time, startup latch and stage ready logic
`include "pfcsg_params.svh"
`default_nettype none
module pfcsg_gate (
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic OVERCURRENT_IN,
    input wire logic ZERO_CURRENT_IN,
    input wire logic OVERVOLT_IN,
    input wire logic LATCH_OFF_INPUT,
    input wire logic SUPPLY_UNDERVOLT_FLAG,
    input wire logic THERMAL_FAULT_IN,
    input wire logic OUT_UNDERVOLT_IN,
    input wire logic STARTUP_CHARGING_IN,
    input wire logic BROWN_OUT_IN,
    input wire logic RAMP_DISCHARGED_FLAG,
    input wire logic OSC_CLOCK_IN,
    input wire logic EA_CHARGING_IN,
    input wire logic ON_TIME_END_IN,
    output logic DRIVE_OUT,
    output logic DEAD_TIME_FLAG,
    output logic ZERO_CURRENT_FLAG,
    output logic OVP_INFORM_OUT,
    output logic STARTUP_PHASE_FLAG,
    output logic STAGE_READY_OUT,
    output logic LATCHED_OFF_OUT,
    output pfcsg_pkg::pfcsg_phase_type PHASE_OUT
);
    import pfcsg_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        pfcsg_phase_type phase;
        logic drive;
        logic dead_time;
        logic zcd;
        logic ovp_inf;
        logic startup_latch;
        logic ready;
        logic latched_off;
        logic clk_pend;
    } pfcsg_state_type;

    pfcsg_state_type st_q;
    pfcsg_state_type st_d;
    logic [`PFCSG_NFLAGS-1:0] raw;
    logic [`PFCSG_NFLAGS-1:0] f;

    // ------------------------------------------------------------
    // flag synchronisation
    // ------------------------------------------------------------
    assign raw[`PFCSG_B_OCP] = OVERCURRENT_IN;
    assign raw[`PFCSG_B_ZCD] = ZERO_CURRENT_IN;
    assign raw[`PFCSG_B_OVP] = OVERVOLT_IN;
    assign raw[`PFCSG_B_LOFF] = LATCH_OFF_INPUT;
    assign raw[`PFCSG_B_SUPPLY_UNDERVOLT_FLAG] = SUPPLY_UNDERVOLT_FLAG;
    assign raw[`PFCSG_B_TSD] = THERMAL_FAULT_IN;
    assign raw[`PFCSG_B_UVP] = OUT_UNDERVOLT_IN;
    assign raw[`PFCSG_B_HVCS] = STARTUP_CHARGING_IN;
    assign raw[`PFCSG_B_BO] = BROWN_OUT_IN;
    assign raw[`PFCSG_B_RAMP] = RAMP_DISCHARGED_FLAG;
    assign raw[`PFCSG_B_CLK] = OSC_CLOCK_IN;
    assign raw[`PFCSG_B_EACHG] = EA_CHARGING_IN;

    pfcsg_sync #(.W(`PFCSG_NFLAGS)) u_sync (
        .clk(SYS_CLK),
        .srst(SRST),
        .async_in(raw),
        .sync_out(f)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic fault_now;
    logic stop_now;
    logic may_set;
    always_comb begin
        st_d = st_q;
        // major faults and not-ready conditions
        fault_now = f[`PFCSG_B_SUPPLY_UNDERVOLT_FLAG] | f[`PFCSG_B_TSD] | f[`PFCSG_B_UVP];
        stop_now = fault_now | f[`PFCSG_B_HVCS] | f[`PFCSG_B_BO]
            | st_q.latched_off | f[`PFCSG_B_LOFF];
        // zero current and dead-time from the synced comparator
        st_d.zcd = f[`PFCSG_B_ZCD];
        st_d.dead_time = f[`PFCSG_B_ZCD] & ~st_q.drive & ~f[`PFCSG_B_OVP];
        st_d.ovp_inf = f[`PFCSG_B_OVP];
        if (f[`PFCSG_B_LOFF]) begin
            st_d.latched_off = 1'b1;
        end
        // oscillator edge is remembered until the switch may turn on
        if (f[`PFCSG_B_CLK]) begin
            st_d.clk_pend = 1'b1;
        end
        may_set = st_q.clk_pend & f[`PFCSG_B_RAMP]
            & (st_q.dead_time | st_q.zcd)
            & ~f[`PFCSG_B_OVP] & ~f[`PFCSG_B_OCP] & ~stop_now;
        case (st_q.phase)
            PFCSG_OFF: begin
                st_d.drive = 1'b0;
                st_d.startup_latch = 1'b1;
                if (!stop_now) begin
                    st_d.phase = PFCSG_WAIT;
                end
            end
            PFCSG_WAIT: begin
                st_d.drive = 1'b0;
                if (stop_now) begin
                    st_d.phase = PFCSG_OFF;
                end else if (may_set) begin
                    st_d.drive = 1'b1;
                    st_d.clk_pend = 1'b0;
                    st_d.phase = PFCSG_ON;
                end
            end
            PFCSG_ON: begin
                if (f[`PFCSG_B_OCP] | f[`PFCSG_B_OVP] | stop_now
                    | ON_TIME_END_IN) begin
                    st_d.drive = 1'b0;
                    st_d.phase = stop_now ? PFCSG_OFF : PFCSG_WAIT;
                end
            end
            default: begin
                st_d.phase = PFCSG_OFF;
                st_d.drive = 1'b0;
            end
        endcase
        // end of startup once the amplifier stops charging
        if (st_q.phase != PFCSG_OFF && !f[`PFCSG_B_EACHG] && !stop_now) begin
            st_d.startup_latch = 1'b0;
        end
        st_d.ready = ~stop_now & ~st_d.startup_latch
            & (st_d.phase != PFCSG_OFF);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            st_q <= '{phase: PFCSG_OFF, drive: 1'b0, dead_time: 1'b0, zcd: 1'b0,
                ovp_inf: 1'b0, startup_latch: 1'b1, ready: 1'b0,
                latched_off: 1'b0, clk_pend: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state register
    assign DRIVE_OUT = st_q.drive;
    assign DEAD_TIME_FLAG = st_q.dead_time;
    assign ZERO_CURRENT_FLAG = st_q.zcd;
    assign OVP_INFORM_OUT = st_q.ovp_inf;
    assign STARTUP_PHASE_FLAG = st_q.startup_latch;
    assign STAGE_READY_OUT = st_q.ready;
    assign LATCHED_OFF_OUT = st_q.latched_off;
    assign PHASE_OUT = st_q.phase;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_ocp_drive_off: assert property (@(posedge SYS_CLK) disable iff (SRST)
        f[`PFCSG_B_OCP] |=> !DRIVE_OUT)
        else $error("drive high after overcurrent");
    a_zcd_follows: assert property (@(posedge SYS_CLK) disable iff (SRST)
        ZERO_CURRENT_FLAG == $past(f[`PFCSG_B_ZCD]))
        else $error("zero-current flag without detection");
    a_turn_on_gate: assert property (@(posedge SYS_CLK) disable iff (SRST)
        $rose(DRIVE_OUT) |-> $past(DEAD_TIME_FLAG | ZERO_CURRENT_FLAG))
        else $error("turn-on while coil current flows");
    a_ovp_drive_off: assert property (@(posedge SYS_CLK) disable iff (SRST)
        f[`PFCSG_B_OVP] |=> !DRIVE_OUT)
        else $error("drive high during overvoltage");
    a_ovp_no_dt: assert property (@(posedge SYS_CLK) disable iff (SRST)
        $past(f[`PFCSG_B_OVP]) |-> OVP_INFORM_OUT && !DEAD_TIME_FLAG)
        else $error("dead-time counted during overvoltage");
    a_ready_startup: assert property (@(posedge SYS_CLK) disable iff (SRST)
        STARTUP_PHASE_FLAG |-> !STAGE_READY_OUT)
        else $error("ready during startup");
    a_off_sets_latch: assert property (@(posedge SYS_CLK) disable iff (SRST)
        PHASE_OUT == PFCSG_OFF |=> STARTUP_PHASE_FLAG)
        else $error("startup latch not set in off phase");
    a_latch_off_hold: assert property (@(posedge SYS_CLK) disable iff (SRST)
        f[`PFCSG_B_LOFF] |=> LATCHED_OFF_OUT ##1 !STAGE_READY_OUT [*3])
        else $error("latch-off not held");
    a_fault_ready: assert property (@(posedge SYS_CLK) disable iff (SRST)
        (f[`PFCSG_B_SUPPLY_UNDERVOLT_FLAG] | f[`PFCSG_B_BO] | f[`PFCSG_B_HVCS]) |=> !STAGE_READY_OUT)
        else $error("ready during fault");
    a_ramp_gate: assert property (@(posedge SYS_CLK) disable iff (SRST)
        $rose(DRIVE_OUT) |-> $past(f[`PFCSG_B_RAMP]))
        else $error("turn-on with ramp not discharged");
endmodule : pfcsg_gate
`default_nettype wire

// ==== verilog/pfcsg_params.svh ====
// constants and functional notes for the switch gating and ready logic
// Functional notes
// - overcurrent resets the pwm latch immediately
// - zero-current flag only while sense below threshold
// - block turn-on while dead-time and zero-current low
// - zero-current marks dead-time, passed to on-time
// - overvoltage keeps switch off until flag clears
// - overvoltage tells on-time logic, no dead-time count
// - stage ready high only in regulated normal operation
// - startup latch set during every off phase
// - startup latch cleared when amplifier stops charging
// - stage ready low throughout startup phase
// - ready low while charging, brown-out, major fault
// - major faults: undervoltage, thermal, output undervoltage
// - latch-off input latches device off, ready low
// - dead-time flag high in dead-time, low otherwise
// - no pwm set while ramp not discharged
`ifndef PFCSG_PARAMS_SVH
`define PFCSG_PARAMS_SVH
// ------------------------------------------------------------
// synchroniser layout
// ------------------------------------------------------------
`define PFCSG_NFLAGS 12
`define PFCSG_B_OCP 0
`define PFCSG_B_ZCD 1
`define PFCSG_B_OVP 2
`define PFCSG_B_LOFF 3
`define PFCSG_B_SUPPLY_UNDERVOLT_FLAG 4
`define PFCSG_B_TSD 5
`define PFCSG_B_UVP 6
`define PFCSG_B_HVCS 7
`define PFCSG_B_BO 8
`define PFCSG_B_RAMP 9
`define PFCSG_B_CLK 10
`define PFCSG_B_EACHG 11
`define PFCSG_SYNC_RST 12'h000
`endif

// ==== verilog/pfcsg_pkg.sv ====
// types of the switch gating and ready logic
`default_nettype none
package pfcsg_pkg;
    // switching phase of the drive
    typedef enum logic [1:0] {
        PFCSG_OFF = 2'b00,
        PFCSG_WAIT = 2'b01,
        PFCSG_ON = 2'b10
    } pfcsg_phase_type;
endpackage : pfcsg_pkg
`default_nettype wire

// ==== verilog/pfcsg_sync.sv ====
// two flip-flop synchroniser for a group of flags
`include "pfcsg_params.svh"
`default_nettype none
module pfcsg_sync #(
    parameter int W = 12
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    // first stage feeds only the second
    always_ff @(posedge clk) begin
        if (srst) begin
            meta_q <= W'(`PFCSG_SYNC_RST);
            sync_out <= W'(`PFCSG_SYNC_RST);
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : pfcsg_sync
`default_nettype wire

// ==== testbench/pfcsg_stage_model.sv ====
// model of the boost switch stage and downstream converter
`default_nettype none
module pfcsg_stage_model (
    input wire logic clk,
    input wire logic drive,
    input wire logic ready,
    output logic zero_current,
    output logic overcurrent,
    output logic conv_en
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] coil_q = 4'h0;
    // coil current rises while on, decays while off
    always_ff @(posedge clk) begin
        if (drive && coil_q != 4'hf) begin
            coil_q <= coil_q + 4'h1;
        end else if (!drive && coil_q != 4'h0) begin
            coil_q <= coil_q - 4'h1;
        end
    end
    // comparator levels seen by the controller
    assign zero_current = (coil_q == 4'h0);
    assign overcurrent = (coil_q > 4'hc);
    // converter only runs on ready
    assign conv_en = ready;
endmodule : pfcsg_stage_model
`default_nettype wire

// ==== testbench/pfcsg_gate_tb.sv ====
// self-checking bench of the switch gating and ready logic
`default_nettype none
module pfcsg_gate_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, srst = 1'b1, ocp_f = 1'b0, ovp = 1'b0, loff = 1'b0;
    logic supply_undervolt_flag = 1'b0, tsd = 1'b0, uvp = 1'b0, hvcs = 1'b0, bo = 1'b0;
    logic ramp = 1'b1, osc = 1'b1, ea = 1'b0, ton_end = 1'b0, zc_blk = 1'b0;
    logic drv, dt, zcf, ovpi, startup_phase_flag, rdy, loffo, zc_m, oc_m;
    logic [1:0] phs;
    int n_fail = 0, n_compared = 0, cyc = 0;
    // rows: ocp supply_undervolt_flag tsd uvp hvcs bo ovp, expected ready, check ready
    // overcurrent is cycle by cycle only, so ready stays high in that row
    logic [8:0] rows [8] = '{9'h103, 9'h081, 9'h041, 9'h021, 9'h011, 9'h009, 9'h004, 9'h003};
    // ------------------------------------------------------------
    // clock, design and stage model
    // ------------------------------------------------------------
    initial begin
        forever #10 clk = ~clk;
    end
    pfcsg_gate pfcsg_gate_inst (.SYS_CLK(clk), .SRST(srst), .OVERCURRENT_IN(oc_m | ocp_f),
        .ZERO_CURRENT_IN(zc_m & ~zc_blk), .OVERVOLT_IN(ovp), .LATCH_OFF_INPUT(loff),
        .SUPPLY_UNDERVOLT_FLAG(supply_undervolt_flag), .THERMAL_FAULT_IN(tsd), .OUT_UNDERVOLT_IN(uvp),
        .STARTUP_CHARGING_IN(hvcs), .BROWN_OUT_IN(bo), .RAMP_DISCHARGED_FLAG(ramp),
        .OSC_CLOCK_IN(osc), .EA_CHARGING_IN(ea), .ON_TIME_END_IN(ton_end), .DRIVE_OUT(drv),
        .DEAD_TIME_FLAG(dt), .ZERO_CURRENT_FLAG(zcf), .OVP_INFORM_OUT(ovpi),
        .STARTUP_PHASE_FLAG(startup_phase_flag), .STAGE_READY_OUT(rdy), .LATCHED_OFF_OUT(loffo),
        .PHASE_OUT(phs));
    pfcsg_stage_model pfcsg_stage_model_inst (.clk(clk), .drive(drv), .ready(rdy),
        .zero_current(zc_m), .overcurrent(oc_m), .conv_en());
    // short on-time: modulator ends each pulse one cycle after drive rises
    always_ff @(posedge clk) begin
        ton_end <= drv;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask : step
    task automatic chk(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            close_out();
        end
    end
    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        step(5);
        #1 chk(startup_phase_flag, 1'b1);
        chk(rdy, 1'b0);
        chk(phs == 2'h0, 1'b1);
        step(5);
        srst <= 1'b0;
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            step(1);
            {ocp_f, supply_undervolt_flag, tsd, uvp, hvcs, bo, ovp} <= rows[i][8:2];
            step(8);
            #1 if (rows[i][0]) chk(rdy, rows[i][1]);
            if (|rows[i][8:2]) chk(drv, 1'b0);
            chk(ovpi, rows[i][2]);
            if (rows[i][2]) chk(dt, 1'b0);
            $display("table row %0d done", i);
        end
        step(1);
        ea <= 1'b1;
        bo <= 1'b1;
        step(6);
        bo <= 1'b0;
        step(10);
        #1 chk(startup_phase_flag, 1'b1);
        chk(rdy, 1'b0);
        step(1);
        ea <= 1'b0;
        step(8);
        #1 chk(startup_phase_flag, 1'b0);
        chk(rdy, 1'b1);
        $display("startup test done");
        step(1);
        ramp <= 1'b0;
        step(6);
        for (int k = 0; k < 6; k++) begin
            step(1);
            #1 chk(drv, 1'b0);
        end
        step(1);
        ramp <= 1'b1;
        zc_blk <= 1'b1;
        step(8);
        #1 chk(zcf, 1'b0);
        chk(dt, 1'b0);
        for (int k = 0; k < 6; k++) begin
            step(1);
            #1 chk(drv, 1'b0);
        end
        step(1);
        zc_blk <= 1'b0;
        for (int k = 0; k < 20 && dt !== 1'b1; k++) begin
            step(1);
            #1;
        end
        chk(dt, 1'b1);
        $display("gating test done");
        step(1);
        loff <= 1'b1;
        step(3);
        loff <= 1'b0;
        step(8);
        #1 chk(loffo, 1'b1);
        chk(rdy, 1'b0);
        chk(drv, 1'b0);
        chk(phs == 2'h0, 1'b1);
        step(1);
        srst <= 1'b1;
        step(10);
        srst <= 1'b0;
        step(1);
        #1 chk(loffo, 1'b0);
        $display("latch-off test done");
        close_out();
    end
endmodule : pfcsg_gate_tb
`default_nettype wire
